/* inc/asq_pkg.sv */
// constants and carrier types for the acquisition scan sequencer
// assumes a single 16 MHz state-machine clock and an external SAR converter handshake
package asq_pkg;
	localparam int CELL_CHANNELS = 12;
	localparam int AUX_CHANNELS = 2;
	localparam int CHANNELS = CELL_CHANNELS + AUX_CHANNELS;
	localparam int CHAN_W = 4;
	localparam int CONV_W = 12;
	localparam int MEAS_W = 14;
	localparam int REG_W = 16;
	localparam int ACC_W = 22;
	localparam int OVS_W = 3;
	localparam int CNT_W = 8;
	localparam logic [REG_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [CHAN_W-1:0] FIRST_AUX = 4'hC;
	localparam logic [1:0] SCAN_COUNT = 2'h2;
	localparam logic [REG_W-CONV_W-1:0] AUX_PAD = 4'h0;
	localparam logic [1:0] LSB_PAD = 2'h0;
	localparam real CLOCK_MHZ = 16.0;

	typedef enum {ST_IDLE, ST_PICK, ST_CONV, ST_WAIT, ST_NEXT, ST_STORE, ST_DONE} asq_state_t;

	typedef struct packed {
		logic [CELL_CHANNELS-1:0] cellEnable;
		logic [AUX_CHANNELS-1:0] auxEnable;
		logic [OVS_W-1:0] oversampleLog2;
	} asq_config_t;

	typedef struct packed {
		logic valid;
		logic [CONV_W-1:0] code;
	} asq_conv_t;
endpackage

/* verilog/asq_accum.sv */
// one per-channel accumulator for the acquisition scan sequencer
// assumes clear and add are not raised together by the sequencer
module asq_accum
(
	input wire logic refClk,
	input wire logic nrst,
	input wire logic clear,
	input wire logic add,
	input wire logic [asq_pkg::CONV_W-1:0] code,
	output logic [asq_pkg::ACC_W-1:0] sum
);
	always_ff @(posedge refClk)
	begin
		if (!nrst || clear)
			sum <= '0;
		else if (add)
			sum <= sum + asq_pkg::ACC_W'(code);
	end
endmodule // asq_accum

/* verilog/asq_sequencer.sv */
// acquisition scan sequencer: conversions, scans, measurement cycles and acquisitions
// assumes ref_clk is the internal 16 MHz oscillator and the converter answers on the same clock
// assumes the converter raises convResult.valid for one cycle some time after each convStart
// assumes cfg is steady while start is high; it is frozen for the rest of the acquisition
// Function
// - Each conversion samples one channel, yields a 12-bit code and adds it to an accumulator.
// - A scan walks all enabled cell channels in order and skips the disabled ones.
// - A measurement cycle is two scans whose two codes per cell channel average into a 14-bit value.
// - Auxiliary channels are converted only once per acquisition, in the second scan of the last measurement cycle.
// - With oversampling, successive measurement cycles are averaged into one 14-bit value per cell channel.
// - Without oversampling, an acquisition is one measurement cycle and its result is that measurement.
// - Auxiliary results are never averaged and are kept as 12-bit values.
// - Every result register is a 16-bit word.
// - The sequencer runs on the internal 16 MHz oscillator clock only.
// - The 14-bit result is stored left-aligned in 16 bits with two zero low bits.
// - A channel not enabled holds zero after the acquisition.
// - Auxiliary channels are converted last in the last measurement cycle.
module asq_sequencer
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic start,
	input wire asq_pkg::asq_config_t cfg,
	output logic busy,
	output logic convStart,
	output logic [asq_pkg::CHAN_W-1:0] convChannel,
	input wire asq_pkg::asq_conv_t convResult,
	output logic [asq_pkg::CHANNELS-1:0][asq_pkg::REG_W-1:0] result,
	output logic done
);
	// sequence position and frozen configuration
	asq_pkg::asq_state_t state;
	asq_pkg::asq_config_t active;
	logic [asq_pkg::CHAN_W-1:0] chan;
	logic scanIdx;
	logic [asq_pkg::CNT_W-1:0] cycleCnt;
	logic [asq_pkg::CNT_W-1:0] cycleTotal;
	logic [asq_pkg::CHANNELS-1:0] enableMask;
	logic [asq_pkg::CHANNELS-1:0] clearAcc;
	logic [asq_pkg::CHANNELS-1:0] addAcc;
	logic [asq_pkg::CHANNELS-1:0][asq_pkg::ACC_W-1:0] sum;
	logic chanLive;
	logic lastChan;
	logic lastScan;
	logic [asq_pkg::CNT_W-1:0] cycleNext;
	logic lastCycle;
	logic endOfCycle;
	logic endOfAcq;
	logic startTaken;
	logic inPick;
	logic inWait;
	logic inNext;
	logic inStore;
	logic [asq_pkg::CHANNELS-1:0][asq_pkg::REG_W-1:0] next_result;

	assign enableMask = {active.auxEnable, active.cellEnable};
	// aux channels sit above the cells so they come last; taken once, on the final scan of the final cycle
	assign chanLive = enableMask[chan] && ((chan < asq_pkg::FIRST_AUX) || (lastScan && lastCycle));
	assign lastChan = (chan == asq_pkg::CHAN_W'(asq_pkg::CHANNELS - 1));
	assign lastScan = scanIdx;
	assign cycleTotal = asq_pkg::CNT_W'(1) << active.oversampleLog2;
	// decoded positions in the sequence
	assign cycleNext = cycleCnt + asq_pkg::CNT_W'(1);
	assign lastCycle = (cycleNext == cycleTotal);
	assign endOfCycle = lastChan && lastScan;
	assign endOfAcq = endOfCycle && lastCycle;
	assign startTaken = (state == asq_pkg::ST_IDLE) && start;
	assign inPick = (state == asq_pkg::ST_PICK);
	assign inWait = (state == asq_pkg::ST_WAIT);
	assign inNext = (state == asq_pkg::ST_NEXT);
	assign inStore = (state == asq_pkg::ST_STORE);

	// one accumulator per channel, all cleared when an acquisition is taken
	genvar g;
	generate
		for (g = 0; g < asq_pkg::CHANNELS; g++)
		begin : gAcc
			assign clearAcc[g] = startTaken;
			assign addAcc[g] = inWait && convResult.valid && (chan == asq_pkg::CHAN_W'(g));
			asq_accum uAcc
			(
				.refClk(ref_clk),
				.nrst(nrst),
				.clear(clearAcc[g]),
				.add(addAcc[g]),
				.code(convResult.code),
				.sum(sum[g])
			);
		end
	endgenerate

	// configuration is frozen for the whole acquisition
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			active <= '0;
		else if (startTaken)
			active <= cfg;
	end

	// sequence state, all on the single oscillator clock
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			state <= asq_pkg::ST_IDLE;
		else
		begin
			unique case (state)
				asq_pkg::ST_IDLE:
				begin
					if (start)
						state <= asq_pkg::ST_PICK;
				end
				asq_pkg::ST_PICK:
				begin
					state <= chanLive ? asq_pkg::ST_CONV : asq_pkg::ST_NEXT;
				end
				asq_pkg::ST_CONV:
				begin
					state <= asq_pkg::ST_WAIT;
				end
				asq_pkg::ST_WAIT:
				begin
					if (convResult.valid)
						state <= asq_pkg::ST_NEXT;
				end
				asq_pkg::ST_NEXT:
				begin
					if (endOfAcq)
						state <= asq_pkg::ST_STORE;
					else
						state <= asq_pkg::ST_PICK;
				end
				asq_pkg::ST_STORE:
				begin
					state <= asq_pkg::ST_DONE;
				end
				asq_pkg::ST_DONE:
				begin
					state <= asq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// channel index within the scan
	always_ff @(posedge ref_clk)
	begin
		if (!nrst || startTaken)
			chan <= '0;
		else if (inNext)
		begin
			if (lastChan)
				chan <= '0;
			else
				chan <= chan + asq_pkg::CHAN_W'(1);
		end
	end

	// first or second scan of the measurement cycle
	always_ff @(posedge ref_clk)
	begin
		if (!nrst || startTaken)
			scanIdx <= 1'b0;
		else if (inNext && lastChan)
			scanIdx <= !scanIdx;
	end

	// measurement cycles finished so far
	always_ff @(posedge ref_clk)
	begin
		if (!nrst || startTaken)
			cycleCnt <= '0;
		else if (inNext && endOfCycle && !lastCycle)
			cycleCnt <= cycleNext;
	end

	// stored words: cells average 2*N codes into 14 bits, aux keep their single 12-bit code
	// doubling then dividing by the cycle count turns the sum of 2*N codes into a 14-bit mean
	always_comb
	begin
		for (int i = 0; i < asq_pkg::CHANNELS; i++)
		begin
			if (!enableMask[i])
				next_result[i] = asq_pkg::RESULT_RESET;
			else if (i >= asq_pkg::CELL_CHANNELS)
				next_result[i] = {asq_pkg::AUX_PAD, asq_pkg::CONV_W'(sum[i])};
			else
				next_result[i] = {asq_pkg::MEAS_W'((sum[i] << 1) >> active.oversampleLog2), asq_pkg::LSB_PAD};
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			result <= {asq_pkg::CHANNELS{asq_pkg::RESULT_RESET}};
		else if (inStore)
			result <= next_result;
	end

	// completion pulse lines up with the new result words
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			done <= 1'b0;
		else
			done <= inStore;
	end

	// channel number holds from one pick to the next
	always_ff @(posedge ref_clk)
	begin
		if (!nrst)
			convChannel <= '0;
		else if (inPick)
			convChannel <= chan;
	end

	// handshake outputs decoded straight from the state
	assign convStart = (state == asq_pkg::ST_CONV);
	assign busy = (state != asq_pkg::ST_IDLE);
endmodule // asq_sequencer

/* testbench/asq_seq_checker.sv */
// assertions on the acquisition scan sequencer ports
// assumes binding to asq_sequencer, one clock domain
module asq_seq_checker
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic start,
	input wire asq_pkg::asq_config_t cfg,
	input wire logic busy,
	input wire logic convStart,
	input wire logic [asq_pkg::CHAN_W-1:0] convChannel,
	input wire logic [asq_pkg::CHANNELS-1:0][asq_pkg::REG_W-1:0] result,
	input wire logic done
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_first;
		##2 convStart && convChannel == 4'h0;
	endsequence
	a_start_taken: assert property (start && !busy |=> busy) else $error("start lost");
	a_first_conv: assert property (start && !busy && cfg.cellEnable[0] |-> s_first) else $error("first");
	a_conv_pulse: assert property (convStart |=> !convStart) else $error("pulse");
	a_conv_range: assert property (convStart |-> busy && convChannel < 4'hE) else $error("chan");
	a_done_pulse: assert property (done |=> !done) else $error("done");
	a_done_after: assert property ($rose(done) |-> !convStart && $past(busy)) else $error("end");
	a_cell_align: assert property (result[0][1:0] == 2'h0 && result[11][1:0] == 2'h0) else $error("lsb");
	a_aux_width: assert property (result[12][15:12] == 4'h0 && result[13][15:12] == 4'h0) else $error("aux");
endmodule // asq_seq_checker
bind asq_sequencer asq_seq_checker chk(.*);

/* testbench/asq_sequencer_tb.sv */
// self-checking bench for the acquisition scan sequencer
// assumes the bench answers conversions itself, one cycle after each request
module asq_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, nrst, start, busy, convStart, done, pend;
	asq_pkg::asq_config_t cfg;
	asq_pkg::asq_conv_t convResult;
	logic [3:0] convChannel, ch;
	logic [13:0][15:0] result;
	logic [13:0] tog;
	logic [3:0] seen[$], want[$];
	int nErrors = 0, testsRun = 0;
	asq_sequencer uut(.*);
	initial
	begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// converter answer: code per channel, low bit alternating per conversion
	always @(posedge ref_clk)
	begin
		#1;
		convResult = {pend, ch, 8'h35} + 13'(pend && tog[ch]);
		if (pend)
			tog[ch] = !tog[ch];
		pend = convStart;
		ch = convChannel;
		if (convStart)
			seen.push_back(convChannel);
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			nErrors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic giveVerdict;
		$display("compared %0d mismatches %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic acq(input asq_pkg::asq_config_t c);
		int i, m, s;
		for (i = 0; i < 8 && busy !== 1'b0; i++)
			@(posedge ref_clk) #1;
		seen = {};
		want = {};
		tog = '0;
		cfg = c;
		start = 1;
		@(posedge ref_clk) #1 start = 0;
		for (i = 0; i < 20000 && done !== 1'b1; i++)
			@(posedge ref_clk) #1;
		check(16'(done), 16'h0001);
		if (done !== 1'b1)
			giveVerdict;
		for (m = 0; m < (1 << c.oversampleLog2); m++)
			for (s = 0; s < 26; s++)
				if (s < 24 ? c.cellEnable[s % 12] : (m == (1 << c.oversampleLog2) - 1) && c.auxEnable[s - 24])
					want.push_back(4'(s < 24 ? s % 12 : s - 12));
		check(16'(seen.size()), 16'(want.size()));
		foreach (want[j])
			check(16'(seen[j]), 16'(want[j]));
		for (s = 0; s < 12; s++)
			check(result[s], c.cellEnable[s] ? {4'(s), 8'h35, 4'h8} : 16'h0000);
		for (s = 0; s < 2; s++)
			check(result[12 + s], c.auxEnable[s] ? {4'h0, 4'(12 + s), 8'h35} : 16'h0000);
	endtask
	task automatic t_full;
		acq({12'hFFF, 2'h3, 3'h0});
	endtask
	task automatic t_sparse;
		acq({12'hA05, 2'h2, 3'h1});
	endtask
	task automatic t_last;
		acq({12'h800, 2'h1, 3'h2});
	endtask
	initial
	begin
		nrst = 0;
		start = 0;
		cfg = '0;
		pend = 0;
		ch = '0;
		convResult = '0;
		repeat (2) @(posedge ref_clk);
		#1 nrst = 1;
		check(result[5], 16'h0000);
		t_full;
		t_sparse;
		t_last;
		giveVerdict;
	end
endmodule // asq_sequencer_tb
